// ### sli_chk.sv
// checker: led, fault and start interlock timing
module sli_chk
  import sli_pkg::*;
#(
  parameter int unsigned DEB_CYC  = 4,
  parameter int unsigned HALF_CYC = 4
) (
  // clock, reset and requests
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        iso_start_en,
  input wire logic [5:0]  din,
  input wire logic [5:0]  din_start_en,
  input wire logic        sw_reset,
  input wire logic        warn_active,
  input wire logic [7:0]  warn_code,
  input wire logic        err_active,
  input wire logic [2:0]  log_sel,
  // status and indicators
  input wire sli_log_type log_entry,
  input wire logic        motor_run,
  input wire logic        ready,
  input wire logic        reinit,
  input wire logic        err_pending,
  input wire logic        led_green,
  input wire logic        led_red
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned still;
  int unsigned quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // green hold while running; cycles since a reset request
  always_ff @(posedge clk) begin
    still <= (motor_run && $stable(led_green)) ? still + 1 : 0;
    quiet <= (sw_reset || din[1]) ? 0 : quiet + 1;
  end
  a_reset_dark: assert property (disable iff (1'b0)
    srst |=> !led_green && !led_red && !motor_run && !ready)
    else $error("output active after reset");
  a_init_wait: assert property ($fell(srst) |-> !ready [*8])
    else $error("ready too early after reset");
  a_run_blinks: assert property (still <= 2 * HALF_CYC)
    else $error("green steady while running");
  a_err_stops: assert property (err_pending [*2] |->
    !motor_run && !led_green) else $error("running in error");
  a_src_interlock: assert property ((iso_start_en == din_start_en[0])
    && $past(iso_start_en == din_start_en[0]) && !motor_run |=> !motor_run)
    else $error("start taken with bad source enables");
  a_err_latched: assert property (err_pending && !sw_reset
    && quiet > DEB_CYC + 4 |=> err_pending)
    else $error("error cleared without reset");
  a_warn_steady: assert property ((warn_active && $stable(warn_code)
    && warn_code > 8'h06 && ready && !err_active && !err_pending) [*4]
    |-> led_red) else $error("red not steady for high code");
  a_log_range: assert property (log_sel > 3'h4 |-> log_entry == '0)
    else $error("unused log slot not zero");
  a_reinit_pulse: assert property (reinit |=> !reinit)
    else $error("reinit longer than one cycle");
  // main scenarios reached
  c_run: cover property ($rose(motor_run));
  c_err: cover property ($rose(err_pending));
  c_reinit: cover property (reinit);
endmodule : sli_chk
// attach to every instance of the top module
bind sli_status_led_start_interlock sli_chk #(
  .DEB_CYC(DEB_CYC), .HALF_CYC(HALF_CYC)) u_chk (.*);

// ### sli_debounce.sv
// debounce filter: level is taken after a stable hold time
module sli_debounce
  import sli_pkg::*;
#(
  parameter int unsigned HOLD_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // raw and filtered level
  input  wire logic raw,
  output logic      level
);
  typedef struct packed {
    logic        level;
    logic [31:0] cnt;
  } sli_deb_type;

  sli_deb_type state;
  sli_deb_type next_state;

  // count while raw differs from the accepted level
  always_comb begin
    next_state = state;
    if (raw == state.level) begin
      next_state.cnt = 32'h0;
    end else if (state.cnt >= 32'(HOLD_CYC - 1)) begin
      next_state.level = raw;
      next_state.cnt   = 32'h0;
    end else begin
      next_state.cnt = state.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;
endmodule : sli_debounce

// ### sli_panel.sv
// partner: panel switches feeding the raw digital inputs
module sli_panel
  import sli_pkg::*;
#(
  parameter int unsigned HOLD = 8
) (
  // clock
  input  wire logic       clk,
  // wanted levels and driven inputs
  input  wire logic [5:0] cmd,
  output logic      [5:0] din
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned age = 0;
  initial din = '0;
  // every level is held HOLD+1 cycles before it may change
  always @(negedge clk) begin
    if (age < HOLD) begin
      age++;
    end else if (cmd !== din) begin
      din <= cmd;
      age = 0;
    end
  end
endmodule : sli_panel

// ### sli_pkg.sv
// package: constants and carriers for status led and start interlock
package sli_pkg;
  // timing figures as printed, and derived cycle counts at 40 MHz
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned DEBOUNCE_MS    = 60;
  localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned WARN_RETIRE_S  = 60;
  localparam int unsigned WARN_RETIRE_CYC = CLK_HZ * WARN_RETIRE_S;
  localparam int unsigned BLINK_MS       = 250;
  localparam int unsigned BLINK_CYC      = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned PAUSE_HALVES   = 6;
  localparam int unsigned NUM_DIN        = 6;
  localparam int unsigned LOG_DEPTH      = 5;
  localparam logic [7:0]  BLINK_CODE_MAX = 8'h06;
  localparam logic [2:0]  IMPORT_BLINKS  = 3'h2;
  localparam logic [2:0]  EXPORT_BLINKS  = 3'h3;
  // digital input positions
  localparam int unsigned DIN_START  = 0;
  localparam int unsigned DIN_RESET  = 1;
  localparam int unsigned DIN_DIR    = 2;
  localparam int unsigned DIN_OFF    = 3;
  localparam int unsigned DIN_IMPORT = 4;
  localparam int unsigned DIN_EXPORT = 5;

  // top-level state machine
  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_READY = 2'b01,
    ST_RUN   = 2'b10,
    ST_ERROR = 2'b11
  } sli_mode_type;

  // card transfer result event
  typedef struct packed {
    logic done;
    logic is_export;
    logic ok;
  } sli_card_type;

  // one fault log entry
  typedef struct packed {
    logic       valid;
    logic       is_error;
    logic [7:0] code;
  } sli_log_type;
endpackage : sli_pkg

// ### sli_status_led_start_interlock.sv
// status leds, fault handling, fault log and start interlock
// Functional notes
// - green blinks while running, steady when stopped
// - off unpowered; idle shows steady green only
// - warning lights red, motor keeps running
// - error stops motor, green off, red on
// - codes up to six blink count, else steady
// - error cleared only by reset, reinitialises
// - warning retires after one minute absent
// - keep last five warnings/errors in log
// - import: two green blinks, both on failure
// - export: three green blinks, both on failure
// - start held at power-on is ignored; a held digital start still runs once its 60 ms filter passes after init
// - isolated or digital start, never both
// - digital inputs need 60 ms stable level
// - six inputs with fixed default functions
// - warnings keep ready; reset clears warning only
module sli_status_led_start_interlock
  import sli_pkg::*;
#(
  parameter int unsigned DEB_CYC    = DEBOUNCE_CYC,
  parameter int unsigned RETIRE_CYC = WARN_RETIRE_CYC,
  parameter int unsigned HALF_CYC   = BLINK_CYC,
  parameter int unsigned INIT_CYC   = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // start sources and their enables
  input  wire logic        iso_start,
  input  wire logic        iso_start_en,
  input  wire logic [5:0]  din,
  input  wire logic [5:0]  din_start_en,
  input  wire logic        sw_reset,
  // fault sources
  input  wire logic        warn_active,
  input  wire logic [7:0]  warn_code,
  input  wire logic        err_active,
  input  wire logic [7:0]  err_code,
  // card transfer result
  input  wire sli_card_type card,
  // fault log read port
  input  wire logic [2:0]  log_sel,
  output sli_log_type      log_entry,
  // drive control and status
  output logic             motor_run,
  output logic             direction,
  output logic             ready,
  output logic             reinit,
  output logic             import_req,
  output logic             export_req,
  output logic             warn_pending,
  output logic             err_pending,
  // indicators
  output logic             led_green,
  output logic             led_red
);
  typedef struct packed {
    // mode and start interlock
    sli_mode_type mode;
    logic [7:0]   init_cnt;
    logic         start_q;
    logic         armed;
    // edge detect copies of filtered inputs
    logic         reset_q;
    logic         imp_q;
    logic         exp_q;
    // pending warning and error with codes
    logic         warn;
    logic [7:0]   wcode;
    logic         err;
    logic [7:0]   ecode;
    logic [31:0]  retire_cnt;
    // blink timing
    logic [31:0]  tick_cnt;
    logic         phase;
    logic [4:0]   step;
    // card result burst
    logic [2:0]   card_left;
    logic         card_fail;
    logic         card_phase;
    // registered outputs
    logic         direction;
    logic         reinit;
    logic         import_req;
    logic         export_req;
    logic         led_green;
    logic         led_red;
    // fault log, slot 0 newest
    sli_log_type [LOG_DEPTH-1:0] log;
  } sli_state_type;

  sli_state_type state;
  sli_state_type next_state;
  // filtered inputs and combinational helpers
  logic [5:0]    din_f;
  logic          tick;
  logic          start_cmd;
  logic          reset_cmd;
  logic          red_on;
  logic [7:0]    show_code;

  // one filter per digital input
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIN; gi++) begin : g_deb
      sli_debounce #(
        .HOLD_CYC (DEB_CYC)
      ) u_deb (
        .clk   (clk),
        .srst  (srst),
        .raw   (din[gi]),
        .level (din_f[gi])
      );
    end
  endgenerate

  // blink half-period enable
  // free-running, so a burst's first half may be short
  assign tick = (state.tick_cnt == 32'(HALF_CYC - 1));

  // start source arbitration
  // both or neither enabled leaves start low
  always_comb begin
    start_cmd = 1'b0;
    if (iso_start_en && !din_start_en[DIN_START]) begin
      start_cmd = iso_start;
    end else if (!iso_start_en && din_start_en[DIN_START]) begin
      start_cmd = din_f[DIN_START];
    end
  end

  assign reset_cmd = sw_reset || (din_f[DIN_RESET] && !state.reset_q);

  // code selection: error outranks warning
  always_comb begin
    show_code = state.wcode;
    if (state.err) begin
      show_code = state.ecode;
    end
  end

  // blink-count red: on during odd halves of first 2*code steps
  always_comb begin
    if (show_code > BLINK_CODE_MAX || show_code == 8'h00) begin
      red_on = 1'b1;
    end else begin
      red_on = state.phase && (state.step < 5'({show_code, 1'b0}));
    end
  end

  // next state
  always_comb begin
    next_state            = state;
    // pulses default low; edge copies follow inputs
    next_state.reinit     = 1'b0;
    next_state.import_req = 1'b0;
    next_state.export_req = 1'b0;
    next_state.reset_q    = din_f[DIN_RESET];
    next_state.imp_q      = din_f[DIN_IMPORT];
    next_state.exp_q      = din_f[DIN_EXPORT];
    next_state.start_q    = start_cmd;
    next_state.direction  = din_f[DIN_DIR];
    next_state.tick_cnt   = tick ? 32'h0 : state.tick_cnt + 32'h1;

    // blink sequencer: 2*code steps then a pause
    // step and phase advance together, so phase is step bit 0
    if (tick) begin
      next_state.phase = !state.phase;
      if (state.step >= 5'({BLINK_CODE_MAX, 1'b0}) + 5'(PAUSE_HALVES) - 5'h1) begin
        next_state.step = 5'h0;
      end else begin
        next_state.step = state.step + 5'h1;
      end
      if (state.card_left != 3'h0) begin
        next_state.card_phase = !state.card_phase;
        if (state.card_phase) begin
          next_state.card_left = state.card_left - 3'h1;
        end
      end
    end

    // card transfer result sets a blink burst
    if (card.done) begin
      next_state.card_left  = card.is_export ? EXPORT_BLINKS
                                             : IMPORT_BLINKS;
      next_state.card_fail  = !card.ok;
      // burst opens dark so every flash shows on green
      next_state.card_phase = 1'b0;
    end

    // import/export requests on rising edges
    next_state.import_req = din_f[DIN_IMPORT] && !state.imp_q;
    next_state.export_req = din_f[DIN_EXPORT] && !state.exp_q;

    // warning capture and retirement
    // each new code is logged unless an error is logged that cycle; an absent cause starts the count
    if (warn_active) begin
      next_state.retire_cnt = 32'h0;
      if (!state.warn || state.wcode != warn_code) begin
        next_state.warn  = 1'b1;
        next_state.wcode = warn_code;
        next_state.log   = {state.log[LOG_DEPTH-2:0],
                            sli_log_type'({1'b1, 1'b0, warn_code})};
      end
    end else if (state.warn) begin
      if (state.retire_cnt >= 32'(RETIRE_CYC - 1)) begin
        next_state.warn       = 1'b0;
        next_state.retire_cnt = 32'h0;
      end else begin
        next_state.retire_cnt = state.retire_cnt + 32'h1;
      end
    end

    // reset request clears a warning without stopping
    // a live cause would relog at once, so it must be gone
    if (reset_cmd && state.mode != ST_ERROR && !warn_active) begin
      next_state.warn = 1'b0;
    end

    // mode sequencing: init, ready, run, latched error
    case (state.mode)
      ST_INIT: begin
        // a start held through init stays unarmed
        next_state.init_cnt = state.init_cnt + 8'h1;
        next_state.armed    = !start_cmd;
        if (state.init_cnt >= 8'(INIT_CYC - 1)) begin
          next_state.mode = ST_READY;
        end
      end
      ST_READY, ST_RUN: begin
        // a dropped start re-arms the interlock
        if (!start_cmd) begin
          next_state.armed = 1'b1;
        end
        if (err_active) begin
          next_state.mode  = ST_ERROR;
          next_state.err   = 1'b1;
          next_state.ecode = err_code;
          next_state.log   = {state.log[LOG_DEPTH-2:0],
                              sli_log_type'({1'b1, 1'b1, err_code})};
        end else if (state.mode == ST_READY) begin
          if (start_cmd && !state.start_q && state.armed
              && !din_f[DIN_OFF]) begin
            next_state.mode = ST_RUN;
          end
        end else if (!start_cmd || din_f[DIN_OFF]) begin
          next_state.mode = ST_READY;
        end
      end
      ST_ERROR: begin
        // only a reset request leaves error; init reruns
        if (reset_cmd) begin
          next_state.mode     = ST_INIT;
          next_state.err      = 1'b0;
          next_state.warn     = 1'b0;
          next_state.init_cnt = 8'h0;
          next_state.reinit   = 1'b1;
        end
      end
      default: begin
        next_state.mode = ST_INIT;
      end
    endcase

    // indicator drive
    // card burst first, then error, then the mode display
    if (state.card_left != 3'h0) begin
      next_state.led_green = state.card_phase;
      next_state.led_red   = state.card_phase && state.card_fail;
    end else if (state.mode == ST_ERROR) begin
      next_state.led_green = 1'b0;
      next_state.led_red   = red_on;
    end else begin
      next_state.led_green = (state.mode == ST_RUN) ? state.phase
                           : (state.mode == ST_READY);
      next_state.led_red   = state.warn && red_on;
    end
  end

  // one register for the whole state
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs from registers
  assign motor_run    = (state.mode == ST_RUN);
  assign ready        = (state.mode == ST_READY) || (state.mode == ST_RUN);
  // pulses, flags and indicators
  assign direction    = state.direction;
  assign reinit       = state.reinit;
  assign import_req   = state.import_req;
  assign export_req   = state.export_req;
  assign warn_pending = state.warn;
  assign err_pending  = state.err;
  assign led_green    = state.led_green;
  assign led_red      = state.led_red;
  // log read port; slots past the depth read zero
  assign log_entry    = (log_sel < 3'(LOG_DEPTH)) ? state.log[log_sel]
                                                  : '0;
endmodule : sli_status_led_start_interlock

// ### sli_status_led_start_interlock_tb.sv
// testbench: status leds, fault handling and start interlock
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %0t mismatch line %0d", $time, `__LINE__); \
  end end
module sli_status_led_start_interlock_tb
  import sli_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned DEB = 4, RET = 50, HALF = 4, INIT = 16;
  logic         clk = 0, srst = 1, iso_start = 1, iso_start_en = 1;
  logic         sw_reset = 0, warn_active = 0, err_active = 0;
  logic [5:0]   cmd = '0, din, din_start_en = '0;
  logic [7:0]   warn_code = '0, err_code = '0;
  logic [2:0]   log_sel = '0;
  sli_card_type card = '0;
  sli_log_type  log_entry;
  logic         motor_run, direction, ready, reinit, import_req;
  logic         export_req, warn_pending, err_pending, led_green, led_red;
  int           error_cnt = 0, check_count = 0, cyc = 0, gf, rr, ir, er;
  sli_status_led_start_interlock #(.DEB_CYC(DEB), .RETIRE_CYC(RET),
    .HALF_CYC(HALF), .INIT_CYC(INIT)) DUT (.*);
  sli_panel #(.HOLD(DEB + 2)) u_panel (.clk(clk), .cmd(cmd), .din(din));
  // expected blink counts
  function automatic int red_blinks(input logic [7:0] c);
    return (c >= 8'h01 && c <= 8'h06) ? int'(c) : 0;
  endfunction : red_blinks
  function automatic int card_blinks(input logic is_export);
    return is_export ? 3 : 2;
  endfunction : card_blinks
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n
  // count green falls, red rises and request pulses over n cycles
  task automatic watch(input int n);
    logic pg, pr;
    gf = 0;
    rr = 0;
    ir = 0;
    er = 0;
    pg = led_green;
    pr = led_red;
    repeat (n) begin
      @(negedge clk);
      if (pg && !led_green) gf++;
      if (!pr && led_red) rr++;
      if (import_req) ir++;
      if (export_req) er++;
      pg = led_green;
      pr = led_red;
    end
  endtask : watch
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial forever #12.5 clk = ~clk;
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end
  // main sequence
  initial begin
    void'($urandom(79));
    cyc_n(10);
    srst = 0;
    cyc_n(INIT + 4);
    `CHK(ready, 1'b1)
    `CHK(led_green, 1'b1)
    `CHK(led_red, 1'b0)
    `CHK(motor_run, 1'b0)
    $display("test idle done");
    iso_start = 0;
    cyc_n(2);
    iso_start = 1;
    cyc_n(3);
    `CHK(motor_run, 1'b1)
    watch(3 * HALF);
    `CHK(gf > 0, 1'b1)
    warn_active = 1;
    warn_code = 8'h09;
    cyc_n(4);
    `CHK(motor_run, 1'b1)
    `CHK(led_red, 1'b1)
    `CHK(ready, 1'b1)
    warn_active = 0;
    cyc_n(RET / 2);
    `CHK(warn_pending, 1'b1)
    cyc_n(RET / 2 + 10);
    `CHK(warn_pending, 1'b0)
    warn_active = 1;
    cyc_n(2);
    `CHK(warn_pending, 1'b1)
    warn_active = 0;
    sw_reset = 1;
    cyc_n(1);
    sw_reset = 0;
    cyc_n(2);
    `CHK(warn_pending, 1'b0)
    `CHK(motor_run, 1'b1)
    iso_start = 0;
    cyc_n(3);
    watch(3 * HALF);
    `CHK(gf, 0)
    `CHK(led_green, 1'b1)
    `CHK(motor_run, 1'b0)
    $display("test run done");
    din_start_en = 6'h01;
    iso_start = 1;
    cyc_n(3);
    `CHK(motor_run, 1'b0)
    iso_start_en = 0;
    cmd = 6'h05;
    cyc_n(2);
    `CHK(motor_run, 1'b0)
    cyc_n(DEB + 6);
    `CHK(motor_run, 1'b1)
    `CHK(direction, 1'b1)
    cmd = 6'h0D;
    cyc_n(DEB + 8);
    `CHK(motor_run, 1'b0)
    cmd = 6'h00;
    din_start_en = 6'h00;
    iso_start = 0;
    cyc_n(2);
    iso_start = 1;
    cyc_n(3);
    `CHK(motor_run, 1'b0)
    $display("test interlock done");
    for (int i = 0; i < 10; i++) begin
      warn_code = (i < 7) ? 8'(i + 1) : 8'($urandom_range(9, 1));
      warn_active = 1;
      cyc_n(2 * HALF);
      watch(18 * HALF);
      `CHK(rr, red_blinks(warn_code))
      if (red_blinks(warn_code) == 0) `CHK(led_red, 1'b1)
    end
    warn_active = 0;
    cyc_n(RET + 10);
    $display("test codes done");
    warn_code = 8'h0A;
    warn_active = 1;
    cyc_n(4);
    err_code = 8'h02;
    err_active = 1;
    cyc_n(2 * HALF);
    `CHK(err_pending, 1'b1)
    `CHK(led_green, 1'b0)
    `CHK(motor_run, 1'b0)
    watch(18 * HALF);
    `CHK(rr, red_blinks(err_code))
    `CHK(log_entry, 10'h302)
    log_sel = 3'h1;
    cyc_n(1);
    `CHK(log_entry, 10'h20A)
    log_sel = 3'h5;
    cyc_n(1);
    `CHK(log_entry, 10'h000)
    sw_reset = 1;
    cyc_n(1);
    sw_reset = 0;
    cyc_n(INIT + 8);
    `CHK(err_pending, 1'b1)
    err_active = 0;
    warn_active = 0;
    cyc_n(20);
    `CHK(err_pending, 1'b1)
    cmd = 6'h02;
    cyc_n(DEB + 4);
    cmd = 6'h00;
    cyc_n(INIT + DEB + 10);
    `CHK(err_pending, 1'b0)
    `CHK(ready, 1'b1)
    $display("test error done");
    for (int k = 0; k < 4; k++) begin
      card = {1'b1, k[1], k[0]};
      cyc_n(1);
      card = '0;
      watch((2 * card_blinks(k[1]) + 6) * HALF);
      `CHK(gf, card_blinks(k[1]))
      `CHK(rr, k[0] ? 0 : card_blinks(k[1]))
    end
    $display("test card done");
    cmd = 6'h10;
    watch(DEB + 6);
    `CHK(ir, 1)
    `CHK(er, 0)
    cmd = 6'h00;
    cyc_n(DEB + 6);
    cmd = 6'h20;
    watch(DEB + 6);
    `CHK(er, 1)
    `CHK(ir, 0)
    cmd = 6'h00;
    $display("test request done");
    results();
  end
endmodule : sli_status_led_start_interlock_tb
